// *** common/tds_pkg.sv ***
// Shared constants, codes and carrier types of the time-of-day scheduler
package tds_pkg;

   // Clock and timing
   localparam int unsigned CLK_MHZ      = 125;
   localparam int unsigned WINDOW_MS    = 5000;
   localparam int unsigned WINDOW_CYC   = WINDOW_MS * CLK_MHZ * 1000;

   // Table geometry
   localparam int unsigned N_ENTRY      = 64;
   localparam int unsigned IDX_W        = 6;
   localparam logic [6:0]  CODE_FIRST   = 7'h01;
   localparam logic [6:0]  CODE_LAST    = 7'h40;
   localparam logic [3:0]  CODE_LEAD    = 4'h3;
   localparam logic [6:0]  CHAN_FIRST   = 7'h01;
   localparam logic [6:0]  CHAN_LAST    = 7'h10;

   // Key codes presented on the keypad port
   localparam logic [3:0]  KEY_DIG_MAX  = 4'h9;
   localparam logic [3:0]  KEY_STAR     = 4'hA;
   localparam logic [3:0]  KEY_POUND    = 4'hB;

   // Entry defaults, the don't-care zero and the decimal digit weight
   localparam logic [6:0]  DEF_TEN      = 7'h0A;
   localparam logic [6:0]  DEF_CHAN     = 7'h01;
   localparam logic [6:0]  VAL_ZERO     = 7'h00;
   localparam logic [6:0]  DEC_TEN      = 7'h0A;

   // AXI4-Lite register map (byte addresses)
   localparam logic [7:0]  REG_CTRL     = 8'h00;
   localparam logic [7:0]  REG_STATUS   = 8'h04;
   localparam logic [7:0]  REG_FIRES    = 8'h08;
   localparam logic [7:0]  REG_LAST     = 8'h0C;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;
   localparam int unsigned CTRL_RUN_BIT = 0;
   localparam logic        CTRL_RUN_RST = 1'b1;

   typedef enum logic [3:0] {
      P_HOUR  = 4'h0,
      P_MIN   = 4'h1,
      P_SEC   = 4'h2,
      P_HALF  = 4'h3,
      P_MONTH = 4'h4,
      P_WDAY  = 4'h5,
      P_DAY   = 4'h6,
      P_CHAN  = 4'h7,
      P_SW    = 4'h8
   } tds_param_t;

   typedef enum logic [2:0] {
      S_IDLE   = 3'b000,
      S_CODE   = 3'b001,
      S_ACT    = 3'b011,
      S_PROMPT = 3'b010,
      S_OPEN   = 3'b110,
      S_WIN    = 3'b111,
      S_ACK    = 3'b101
   } tds_state_t;

   // Real-time clock view, twelve-hour form
   typedef struct packed {
      logic [6:0] month;
      logic [6:0] day;
      logic [3:0] wday;
      logic [6:0] hour;
      logic [6:0] minute;
      logic [6:0] second;
      logic       pm;
   } tds_rtc_t;

   // One schedule entry; zero in month, wday or day disables that match
   typedef struct packed {
      logic       en;
      logic [6:0] hour;
      logic [6:0] minute;
      logic [6:0] second;
      logic       pm;
      logic [6:0] month;
      logic [3:0] wday;
      logic [6:0] day;
      logic [6:0] chan;
      logic       sw_b;
   } tds_entry_t;

endpackage

// *** verilog/tds_window_timer.sv ***
// Entry-window timer for the keypad setup dialogue
`timescale 1ns/1ps
`default_nettype none
module tds_window_timer #(
   parameter int unsigned CYCLES = tds_pkg::WINDOW_CYC
) (
   // Clock, reset and enable
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic ce,
   // Control
   input  wire logic start,
   input  wire logic stop,
   // Status
   output logic      expired
);
   logic [31:0] cnt_reg;
   logic        run_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_reg <= 32'h0000_0000;
         run_reg <= 1'b0;
         expired <= 1'b0;
      end else if (ce) begin
         expired <= 1'b0;
         if (start) begin
            cnt_reg <= 32'(CYCLES);
            run_reg <= 1'b1;
         end else if (stop) begin
            run_reg <= 1'b0;
         end else if (run_reg) begin
            // Expiry lands exactly CYCLES enables after start
            if (cnt_reg <= 32'h0000_0001) begin
               run_reg <= 1'b0;
               expired <= 1'b1;
            end
            cnt_reg <= cnt_reg - 32'h0000_0001;
         end
      end
   end
endmodule
`default_nettype wire

// *** verilog/tds_match.sv ***
// Compares one schedule entry against the real-time clock
`timescale 1ns/1ps
`default_nettype none
module tds_match (
   // Operands
   input  wire tds_pkg::tds_entry_t entry,
   input  wire tds_pkg::tds_rtc_t   rtc,
   // Result
   output logic                     hit,
   output logic [4:0]               sw_idx
);
   // Zero in the stored field means the field is not compared
   function automatic logic opt_eq(input logic [6:0] v, input logic [6:0] r);
      opt_eq = (v == tds_pkg::VAL_ZERO) || (v == r);
   endfunction

   logic       month_off;
   logic       wday_ok;
   logic       chan_ok;
   logic [6:0] chan_m1;

   always_comb begin
      month_off = (entry.month == tds_pkg::VAL_ZERO);
      // Weekday only counts while month matching is off
      wday_ok   = !month_off || opt_eq({3'b000, entry.wday},
                                       {3'b000, rtc.wday});
      chan_ok   = (entry.chan >= tds_pkg::CHAN_FIRST) &&
                  (entry.chan <= tds_pkg::CHAN_LAST);
      chan_m1   = entry.chan - tds_pkg::CHAN_FIRST;
      hit = entry.en && chan_ok &&
            (entry.hour == rtc.hour) && (entry.pm == rtc.pm) &&
            (entry.minute == rtc.minute) &&
            (entry.second == rtc.second) &&
            opt_eq(entry.month, rtc.month) &&
            wday_ok && opt_eq(entry.day, rtc.day);
      sw_idx = {chan_m1[3:0], entry.sw_b};
   end
endmodule
`default_nettype wire

// *** verilog/tds_scheduler.sv ***
// Time-of-day scheduler: keypad setup dialogue, entry table, firing scan
`timescale 1ns/1ps
`default_nettype none
module tds_scheduler #(
   parameter int unsigned WINDOW_CYCLES = tds_pkg::WINDOW_CYC
) (
   // Clock, reset, enable
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              ce,
   // AXI4-Lite write
   input  wire logic [7:0]        s_awaddr,
   input  wire logic              s_awvalid,
   output logic                   s_awready,
   input  wire logic [31:0]       s_wdata,
   input  wire logic [3:0]        s_wstrb,
   input  wire logic              s_wvalid,
   output logic                   s_wready,
   output logic [1:0]             s_bresp,
   output logic                   s_bvalid,
   input  wire logic              s_bready,
   // AXI4-Lite read
   input  wire logic [7:0]        s_araddr,
   input  wire logic              s_arvalid,
   output logic                   s_arready,
   output logic [31:0]            s_rdata,
   output logic [1:0]             s_rresp,
   output logic                   s_rvalid,
   input  wire logic              s_rready,
   // Keypad tones from the operator
   input  wire logic              key_valid,
   input  wire logic [3:0]        key_code,
   // Real-time clock
   input  wire logic              rtc_tick,
   input  wire tds_pkg::tds_rtc_t rtc,
   // Spoken prompts and beeps
   output logic                   prompt_valid,
   output logic [3:0]             prompt_param,
   output logic [6:0]             prompt_value,
   output logic                   window_open,
   output logic                   beep_valid,
   output logic                   beep_double,
   // Command-channel switch activation
   output logic                   fire_valid,
   output logic [4:0]             fire_switch
);
   ////////////////////////////////////////////////////////////////////////
   // Declarations
   tds_pkg::tds_entry_t tbl [tds_pkg::N_ENTRY];
   tds_pkg::tds_state_t state_reg;
   tds_pkg::tds_param_t param_reg;
   tds_pkg::tds_param_t param_next;
   logic [tds_pkg::IDX_W-1:0] sel_reg;
   logic [tds_pkg::IDX_W-1:0] scan_idx_reg;
   logic [6:0]  acc_reg;
   logic [1:0]  ndig_reg;
   logic        accepted_reg;
   logic        run_reg;
   logic        scan_busy_reg;
   logic [31:0] fires_reg;
   logic [7:0]  awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        key_dig;
   logic [6:0]  acc_in;
   logic        win_start;
   logic        win_stop;
   logic        win_expired;
   logic        m_hit;
   logic [4:0]  m_sw;
   logic        do_write;
   logic        store;
   logic [6:0]  store_val;

   // Current value of one parameter of an entry
   function automatic logic [6:0] field_of(input tds_pkg::tds_entry_t e,
                                           input tds_pkg::tds_param_t p);
      unique case (p)
         tds_pkg::P_HOUR:  field_of = e.hour;
         tds_pkg::P_MIN:   field_of = e.minute;
         tds_pkg::P_SEC:   field_of = e.second;
         tds_pkg::P_HALF:  field_of = {6'b00_0000, e.pm};
         tds_pkg::P_MONTH: field_of = e.month;
         tds_pkg::P_WDAY:  field_of = {3'b000, e.wday};
         tds_pkg::P_DAY:   field_of = e.day;
         tds_pkg::P_CHAN:  field_of = e.chan;
         tds_pkg::P_SW:    field_of = {6'b00_0000, e.sw_b};
         default:          field_of = tds_pkg::VAL_ZERO;
      endcase
   endfunction

   // Star/pound parameters versus digit parameters
   function automatic logic is_symbol(input tds_pkg::tds_param_t p);
      is_symbol = (p == tds_pkg::P_HALF) || (p == tds_pkg::P_SW);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Helpers
   tds_window_timer #(.CYCLES(WINDOW_CYCLES)) u_timer (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .start   (win_start),
      .stop    (win_stop),
      .expired (win_expired)
   );

   tds_match u_match (
      .entry  (tbl[scan_idx_reg]),
      .rtc    (rtc),
      .hit    (m_hit),
      .sw_idx (m_sw)
   );

   always_comb begin
      key_dig   = key_valid && (key_code <= tds_pkg::KEY_DIG_MAX);
      acc_in    = 7'(acc_reg * tds_pkg::DEC_TEN) + {3'b000, key_code};
      win_start = (state_reg == tds_pkg::S_OPEN);
      store     = 1'b0;
      store_val = acc_in;
      if (state_reg == tds_pkg::S_WIN && key_valid) begin
         if (is_symbol(param_reg)) begin
            // Pound is after-noon or switch B, star the other choice
            // Only star or pound answers; stray codes leave the field
            store     = (key_code == tds_pkg::KEY_STAR) ||
                        (key_code == tds_pkg::KEY_POUND);
            store_val = {6'b00_0000, key_code == tds_pkg::KEY_POUND};
         end else if (key_dig) begin
            // Weekday takes one digit, every other field two
            store = (param_reg == tds_pkg::P_WDAY) ||
                    (ndig_reg != 2'd0);
         end
      end
      win_stop  = store;
      // Weekday asked only while month matching is off
      unique case (param_reg)
         tds_pkg::P_HOUR:  param_next = tds_pkg::P_MIN;
         tds_pkg::P_MIN:   param_next = tds_pkg::P_SEC;
         tds_pkg::P_SEC:   param_next = tds_pkg::P_HALF;
         tds_pkg::P_HALF:  param_next = tds_pkg::P_MONTH;
         tds_pkg::P_MONTH: param_next = (tbl[sel_reg].month ==
                                         tds_pkg::VAL_ZERO) ?
                                        tds_pkg::P_WDAY : tds_pkg::P_DAY;
         tds_pkg::P_WDAY:  param_next = tds_pkg::P_DAY;
         tds_pkg::P_DAY:   param_next = tds_pkg::P_CHAN;
         tds_pkg::P_CHAN:  param_next = tds_pkg::P_SW;
         default:          param_next = tds_pkg::P_HOUR;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Setup dialogue
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg    <= tds_pkg::S_IDLE;
         param_reg    <= tds_pkg::P_HOUR;
         sel_reg      <= '0;
         acc_reg      <= tds_pkg::VAL_ZERO;
         ndig_reg     <= 2'd0;
         accepted_reg <= 1'b0;
      end else if (ce) begin
         unique case (state_reg)
            tds_pkg::S_IDLE: begin
               if (key_dig && key_code == tds_pkg::CODE_LEAD) begin
                  state_reg <= tds_pkg::S_CODE;
                  acc_reg   <= tds_pkg::VAL_ZERO;
                  ndig_reg  <= 2'd0;
               end
            end
            tds_pkg::S_CODE: begin
               if (key_valid && !key_dig) begin
                  state_reg <= tds_pkg::S_IDLE;
               end else if (key_dig) begin
                  acc_reg  <= acc_in;
                  ndig_reg <= ndig_reg + 2'd1;
                  if (ndig_reg != 2'd0) begin
                     if (acc_in >= tds_pkg::CODE_FIRST &&
                         acc_in <= tds_pkg::CODE_LAST) begin
                        state_reg <= tds_pkg::S_ACT;
                        sel_reg   <= 6'(acc_in - tds_pkg::CODE_FIRST);
                     end else begin
                        state_reg <= tds_pkg::S_IDLE;
                     end
                  end
               end
            end
            tds_pkg::S_ACT: begin
               if (key_valid && key_code == tds_pkg::KEY_POUND) begin
                  state_reg <= tds_pkg::S_PROMPT;
                  param_reg <= tds_pkg::P_HOUR;
               end else if (key_valid) begin
                  state_reg <= tds_pkg::S_IDLE;
               end
            end
            tds_pkg::S_PROMPT: state_reg <= tds_pkg::S_OPEN;
            tds_pkg::S_OPEN: begin
               state_reg <= tds_pkg::S_WIN;
               acc_reg   <= tds_pkg::VAL_ZERO;
               ndig_reg  <= 2'd0;
            end
            tds_pkg::S_WIN: begin
               if (key_dig) begin
                  acc_reg  <= acc_in;
                  ndig_reg <= ndig_reg + 2'd1;
               end
               if (store) begin
                  state_reg    <= tds_pkg::S_ACK;
                  accepted_reg <= 1'b1;
               end else if (win_expired) begin
                  // Window closed without a value: field kept
                  state_reg    <= tds_pkg::S_ACK;
                  accepted_reg <= 1'b0;
               end
            end
            tds_pkg::S_ACK: begin
               if (param_reg == tds_pkg::P_SW) begin
                  state_reg <= tds_pkg::S_IDLE;
               end else begin
                  state_reg <= tds_pkg::S_PROMPT;
                  param_reg <= param_next;
               end
            end
            default: state_reg <= tds_pkg::S_IDLE;
         endcase
      end
   end

   // Prompt, window-open and acknowledge outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prompt_valid <= 1'b0;
         prompt_param <= 4'h0;
         prompt_value <= tds_pkg::VAL_ZERO;
         window_open  <= 1'b0;
         beep_valid   <= 1'b0;
         beep_double  <= 1'b0;
      end else if (ce) begin
         prompt_valid <= (state_reg == tds_pkg::S_PROMPT);
         window_open  <= (state_reg == tds_pkg::S_OPEN);
         beep_valid   <= (state_reg == tds_pkg::S_ACK);
         if (state_reg == tds_pkg::S_PROMPT) begin
            prompt_param <= param_reg;
            prompt_value <= field_of(tbl[sel_reg], param_reg);
         end
         if (state_reg == tds_pkg::S_ACK) begin
            beep_double <= accepted_reg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Entry table
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < tds_pkg::N_ENTRY; i++) begin
            tbl[i].en     <= 1'b0;
            tbl[i].hour   <= tds_pkg::DEF_TEN;
            tbl[i].minute <= tds_pkg::DEF_TEN;
            tbl[i].second <= tds_pkg::DEF_TEN;
            tbl[i].pm     <= 1'b0;
            tbl[i].month  <= tds_pkg::DEF_TEN;
            tbl[i].wday   <= 4'h0;
            tbl[i].day    <= tds_pkg::DEF_TEN;
            tbl[i].chan   <= tds_pkg::DEF_CHAN;
            tbl[i].sw_b   <= 1'b0;
         end
      end else if (ce) begin
         if (state_reg == tds_pkg::S_ACT && key_valid) begin
            if (key_code == tds_pkg::KEY_POUND) begin
               tbl[sel_reg].en <= 1'b1;
            end else if (key_code == tds_pkg::KEY_STAR) begin
               tbl[sel_reg].en <= 1'b0;
            end
         end
         if (store) begin
            unique case (param_reg)
               tds_pkg::P_HOUR:  tbl[sel_reg].hour   <= store_val;
               tds_pkg::P_MIN:   tbl[sel_reg].minute <= store_val;
               tds_pkg::P_SEC:   tbl[sel_reg].second <= store_val;
               tds_pkg::P_HALF:  tbl[sel_reg].pm     <= store_val[0];
               tds_pkg::P_MONTH: tbl[sel_reg].month  <= store_val;
               tds_pkg::P_WDAY:  tbl[sel_reg].wday   <= store_val[3:0];
               tds_pkg::P_DAY:   tbl[sel_reg].day    <= store_val;
               tds_pkg::P_CHAN:  tbl[sel_reg].chan   <= store_val;
               default:          tbl[sel_reg].sw_b   <= store_val[0];
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Firing scan: one pass over the table per second tick
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scan_busy_reg <= 1'b0;
         scan_idx_reg  <= '0;
         fire_valid    <= 1'b0;
         fire_switch   <= 5'h00;
         fires_reg     <= 32'h0000_0000;
      end else if (ce) begin
         fire_valid <= 1'b0;
         if (rtc_tick && run_reg && !scan_busy_reg) begin
            scan_busy_reg <= 1'b1;
            scan_idx_reg  <= '0;
         end else if (scan_busy_reg) begin
            // Each entry is visited once per pass, so fires once
            if (m_hit) begin
               fire_valid  <= 1'b1;
               fire_switch <= m_sw;
               fires_reg   <= fires_reg + 32'h0000_0001;
            end
            scan_idx_reg <= scan_idx_reg + 6'd1;
            if (&scan_idx_reg) begin
               scan_busy_reg <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel
   always_comb do_write = !s_awready && !s_wready && !s_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_awready  <= 1'b1;
         s_wready   <= 1'b1;
         s_bvalid   <= 1'b0;
         s_bresp    <= tds_pkg::RESP_OKAY;
         awaddr_reg <= 8'h00;
         wdata_reg  <= 32'h0000_0000;
         wstrb_reg  <= 4'h0;
         run_reg    <= tds_pkg::CTRL_RUN_RST;
      end else if (ce) begin
         if (s_awvalid && s_awready) begin
            awaddr_reg <= s_awaddr;
            s_awready  <= 1'b0;
         end
         if (s_wvalid && s_wready) begin
            wdata_reg <= s_wdata;
            wstrb_reg <= s_wstrb;
            s_wready  <= 1'b0;
         end
         if (do_write) begin
            s_bvalid <= 1'b1;
            s_bresp  <= tds_pkg::RESP_OKAY;
            if (awaddr_reg == tds_pkg::REG_CTRL) begin
               if (wstrb_reg[0]) begin
                  run_reg <= wdata_reg[tds_pkg::CTRL_RUN_BIT];
               end
            end else if (awaddr_reg != tds_pkg::REG_STATUS &&
                         awaddr_reg != tds_pkg::REG_FIRES &&
                         awaddr_reg != tds_pkg::REG_LAST) begin
               s_bresp <= tds_pkg::RESP_SLVERR;
            end
         end
         if (s_bvalid && s_bready) begin
            s_bvalid  <= 1'b0;
            s_awready <= 1'b1;
            s_wready  <= 1'b1;
         end
      end
   end

   // AXI4-Lite read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_arready <= 1'b1;
         s_rvalid  <= 1'b0;
         s_rdata   <= 32'h0000_0000;
         s_rresp   <= tds_pkg::RESP_OKAY;
      end else if (ce) begin
         if (s_arvalid && s_arready) begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b1;
            s_rresp   <= tds_pkg::RESP_OKAY;
            unique case (s_araddr)
               tds_pkg::REG_CTRL:   s_rdata <= {31'h0, run_reg};
               tds_pkg::REG_STATUS: s_rdata <= {18'h0, scan_busy_reg,
                                                state_reg, param_reg,
                                                sel_reg};
               tds_pkg::REG_FIRES:  s_rdata <= fires_reg;
               tds_pkg::REG_LAST:   s_rdata <= {27'h0, fire_switch};
               default: begin
                  s_rdata <= 32'h0000_0000;
                  s_rresp <= tds_pkg::RESP_SLVERR;
               end
            endcase
         end
         if (s_rvalid && s_rready) begin
            s_rvalid  <= 1'b0;
            s_arready <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// *** tb/tds_operator.sv ***
// Remote operator model keying tones into the scheduler
`timescale 1ns/1ps
`default_nettype none
module tds_operator (
   // Clock
   input  wire logic aclk,
   // Keypad tones
   output logic       key_valid,
   output logic [3:0] key_code
);
   initial key_valid = 1'h0;
   initial key_code = 4'h0;
   // One key per pulse; code scrambled between keys
   task press(input logic [3:0] k);
      key_valid <= 1'h1;
      key_code <= k;
      @(posedge aclk);
      key_valid <= 1'h0;
      key_code <= ~k;
      @(posedge aclk);
   endtask
   // Two digits, tens first, inside the window
   task two(input int v);
      press(4'(v / 10));
      press(4'(v % 10));
   endtask
endmodule
`default_nettype wire

// *** tb/tds_scheduler_sva.sv ***
// Port checks for the scheduler
`timescale 1ns/1ps
`default_nettype none
module tds_scheduler_sva (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus
   input wire logic s_arvalid,
   input wire logic s_arready,
   input wire logic s_rvalid,
   input wire logic s_bvalid,
   input wire logic s_bready,
   // Dialogue and firing
   input wire logic prompt_valid,
   input wire logic window_open,
   input wire logic beep_valid,
   input wire logic beep_double,
   input wire logic fire_valid
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_prompt_opens: assert property (prompt_valid |=> window_open)
      else $error("no window after prompt");
   a_prompt_pulse: assert property (prompt_valid |=> !prompt_valid)
      else $error("prompt longer than a cycle");
   a_open_pulse: assert property (window_open |=> !window_open)
      else $error("window beep longer than a cycle");
   a_reset_quiet: assert property ($rose(aresetn) |-> !fire_valid [*2])
      else $error("fire right after reset");
   a_beep_pulse: assert property (beep_valid |=> !beep_valid)
      else $error("beep longer than a cycle");
   a_double_held: assert property (!beep_valid |-> $stable(beep_double))
      else $error("beep count changed without a beep");
   a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
      else $error("read answer late");
   a_resp_holds: assert property (s_bvalid && !s_bready |=> s_bvalid)
      else $error("write answer dropped");
   c_fire: cover property (fire_valid);
   c_two_beeps: cover property (beep_valid && beep_double);
   c_one_beep: cover property (beep_valid && !beep_double);
endmodule
bind tds_scheduler tds_scheduler_sva u_sva (.*);
`default_nettype wire

// *** tb/test_tds_scheduler.sv ***
// Self-checking bench for the time-of-day scheduler
`timescale 1ns/1ps
`default_nettype none
module test_tds_scheduler;
   logic aclk = '0, aresetn = '0, ce = 1'h1, rtc_tick = '0;
   logic s_awvalid = '0, s_wvalid = '0, s_bready = '0, s_arvalid = '0;
   logic s_rready = '0, s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [7:0] s_awaddr = '0, s_araddr = '0;
   logic [31:0] s_wdata = '0, s_rdata;
   logic [3:0] s_wstrb = 4'hf, key_code, prompt_param;
   logic [1:0] s_bresp, s_rresp;
   logic key_valid, prompt_valid, window_open, beep_valid, beep_double;
   logic fire_valid;
   logic [6:0] prompt_value;
   logic [4:0] fire_switch;
   tds_pkg::tds_rtc_t rtc = '0;
   int miscompares = 0, checks = 0, cyc = 0;
   tds_scheduler #(.WINDOW_CYCLES(20)) u_dut (.*);
   tds_operator u_op (.*);
   always #4 aclk = ~aclk;
   task chk(input logic [31:0] g, input logic [31:0] x);
      checks++;
      if (g !== x) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Hang guard: the whole run needs about nine hundred cycles
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         miscompares++;
         tally_and_finish;
      end
   end
   // Switch index a firing entry drives: two per channel, B the odd one
   function automatic int exp_sw(input int c, input int b);
      return (c - 1) * 2 + b;
   endfunction
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_on, w_on;
      aw_on = 1'h1;
      w_on = 1'h1;
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'h1;
      s_wvalid <= 1'h1;
      s_bready <= 1'h1;
      // Own valids are tracked locally; each drops at its own handshake
      while (aw_on || w_on) begin
         @(posedge aclk);
         if (aw_on && s_awready) aw_on = 1'h0;
         if (w_on && s_wready) w_on = 1'h0;
         s_awvalid <= aw_on;
         s_wvalid <= w_on;
      end
      while (!s_bvalid) @(posedge aclk);
      s_bready <= 1'h0;
      chk(s_bresp, tds_pkg::RESP_OKAY);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] r);
      s_araddr <= a;
      s_arvalid <= 1'h1;
      s_rready <= 1'h1;
      do @(posedge aclk); while (!s_arready);
      s_arvalid <= 1'h0;
      while (!s_rvalid) @(posedge aclk);
      s_rready <= 1'h0;
      chk(s_rdata, x);
      chk(s_rresp, r);
   endtask
   // One parameter: check its prompt, then key n symbols or let it lapse
   task step(input tds_pkg::tds_param_t p, input int v, input int n);
      while (!prompt_valid) @(posedge aclk);
      chk(prompt_param, p);
      if (p == tds_pkg::P_HOUR) chk(prompt_value, tds_pkg::DEF_TEN);
      while (!window_open) @(posedge aclk);
      if (n == 2) u_op.two(v);
      if (n == 1) u_op.press(4'(v));
      while (!beep_valid) @(posedge aclk);
      chk(beep_double, n != 0);
   endtask
   task tick(input int e);
      int n;
      n = 0;
      rtc_tick <= 1'h1;
      @(posedge aclk);
      rtc_tick <= 1'h0;
      repeat (70) begin
         @(posedge aclk);
         if (fire_valid === 1'h1) n++;
      end
      chk(n, e);
   endtask
   initial begin
      int e, h, m, s, c, b;
      void'($urandom(58));
      e = $urandom_range(64, 1);
      h = $urandom_range(12, 1);
      m = $urandom_range(59, 0);
      s = $urandom_range(59, 0);
      c = $urandom_range(16, 1);
      b = $urandom_range(1, 0);
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      u_op.press(tds_pkg::CODE_LEAD);
      u_op.two(e);
      u_op.press(tds_pkg::KEY_POUND);
      step(tds_pkg::P_HOUR, h, 2);
      step(tds_pkg::P_MIN, m, 2);
      step(tds_pkg::P_SEC, s, 2);
      step(tds_pkg::P_HALF, 11, 1);
      step(tds_pkg::P_MONTH, 0, 0);
      step(tds_pkg::P_DAY, 0, 2);
      step(tds_pkg::P_CHAN, c, 2);
      step(tds_pkg::P_SW, 10 + b, 1);
      $display("dialogue test done");
      rtc <= {7'h0a, 7'(c), 4'h3, 7'(h), 7'(m), 7'(s), 1'h1};
      tick(1);
      chk(fire_switch, exp_sw(c, b));
      rtc.pm <= 1'h0;
      tick(0);
      $display("firing test done");
      rd(tds_pkg::REG_CTRL, 32'h0000_0001, tds_pkg::RESP_OKAY);
      rd(tds_pkg::REG_FIRES, 32'h0000_0001, tds_pkg::RESP_OKAY);
      rd(8'h10, 32'h0000_0000, tds_pkg::RESP_SLVERR);
      wr(tds_pkg::REG_CTRL, 32'h0000_0000);
      rtc.pm <= 1'h1;
      tick(0);
      wr(tds_pkg::REG_CTRL, 32'h0000_0001);
      u_op.press(tds_pkg::CODE_LEAD);
      u_op.two(e);
      u_op.press(tds_pkg::KEY_STAR);
      tick(0);
      $display("bus and disable test done");
      e = e % 64 + 1;
      u_op.press(tds_pkg::CODE_LEAD);
      u_op.two(e);
      u_op.press(tds_pkg::KEY_POUND);
      step(tds_pkg::P_HOUR, 0, 0);
      step(tds_pkg::P_MIN, 0, 0);
      step(tds_pkg::P_SEC, 0, 0);
      step(tds_pkg::P_HALF, 0, 0);
      step(tds_pkg::P_MONTH, 0, 2);
      step(tds_pkg::P_WDAY, 4, 1);
      step(tds_pkg::P_DAY, 0, 0);
      step(tds_pkg::P_CHAN, 0, 0);
      step(tds_pkg::P_SW, 0, 0);
      rtc <= {7'h05, 7'h0a, 4'h4, 7'h0a, 7'h0a, 7'h0a, 1'h0};
      tick(1);
      chk(fire_switch, exp_sw(1, 0));
      rtc.wday <= 4'h3;
      tick(0);
      rtc.wday <= 4'h4;
      ce <= 1'h0;
      tick(0);
      ce <= 1'h1;
      tick(1);
      $display("weekly and enable test done");
      tally_and_finish;
   end
endmodule
`default_nettype wire
